// [hw/tcdr_top.v]
// Host configuration store: probe selector, dither enables, gain loop RAM,
// and the A/B coefficient memories of both FIR stages.
// Assumes the 8-bit host port is synchronous to ref_clk_in.
module tcdr_top (
   input wire ref_clk_in,
   input wire rst_in,
   input wire ce_in,
   input wire up_sel_n_in,
   input wire up_wr_n_in,
   input wire up_rd_n_in,
   input wire [7:0] up_addr_in,
   input wire [7:0] up_data_in,
   output reg [7:0] up_data_out,
   output wire up_data_oe_out,
   input wire [19:0] f1_in_ai_in,
   input wire [19:0] f1_in_aq_in,
   input wire [19:0] f1_in_bi_in,
   input wire [19:0] f1_in_bq_in,
   input wire [19:0] f1_out_ai_in,
   input wire [19:0] f1_out_aq_in,
   input wire [19:0] f1_out_bi_in,
   input wire [19:0] f1_out_bq_in,
   input wire [16:0] nco_a_cos_in,
   input wire [16:0] nco_a_sin_in,
   input wire [16:0] nco_b_cos_in,
   input wire [16:0] nco_b_sin_in,
   input wire [14:0] mix_ai_in,
   input wire [14:0] mix_aq_in,
   input wire [14:0] mix_bi_in,
   input wire [14:0] mix_bq_in,
   input wire [8:0] agc_cic_a_in,
   input wire [8:0] agc_cic_b_in,
   output reg [19:0] probe_out,
   output wire probe_en_out,
   output wire dither_enable_chan_a_out,
   output wire dither_enable_chan_b_out,
   input wire [3:0] gain_pair_idx_a_in,
   output wire [15:0] gain_pair_a_out,
   input wire [3:0] gain_pair_idx_b_in,
   output wire [15:0] gain_pair_b_out,
   input wire [3:0] f1_coef_idx_a_in,
   output reg [15:0] f1_coef_a_out,
   input wire [3:0] f1_coef_idx_b_in,
   output reg [15:0] f1_coef_b_out,
   input wire [4:0] f2_coef_idx_a_in,
   output reg [15:0] f2_coef_a_out,
   input wire [4:0] f2_coef_idx_b_in,
   output reg [15:0] f2_coef_b_out
);
`include "tcdr_regs.vh"

   // Read source codes carried from the access cycle to the output stage
   localparam SRC_NONE = 3'h0;
   localparam SRC_REG = 3'h1;
   localparam SRC_GAIN = 3'h2;
   localparam SRC_F1A = 3'h3;
   localparam SRC_F1B = 3'h4;
   localparam SRC_F2A = 3'h5;
   localparam SRC_F2B = 3'h6;

   // Window decode shared by write and read paths
   function in_win;
      input [7:0] a;
      input [7:0] lo;
      input [7:0] hi;
      begin
         in_win = (a >= lo) && (a <= hi);
      end
   endfunction

   reg [7:0] probe_ctl_r;
   reg [`TCDR_FIR_CTL_W-1:0] f1_ctl_r;
   reg [`TCDR_FIR_CTL_W-1:0] f2_ctl_r;
   reg [2:0] rd_src_r;
   reg [7:0] reg_rdata_r;
   reg [7:0] reg_rdata_nxt;
   reg [19:0] probe_nxt;
   reg [2:0] rd_src_nxt;

   wire host_wr;
   wire host_rd;
   wire hit_probe;
   wire hit_f1_ctl;
   wire hit_f2_ctl;
   wire hit_gain;
   wire hit_f1;
   wire hit_f2;
   wire bank_hit;
   wire [7:0] gain_diff;
   wire [7:0] f1_diff;
   wire [7:0] f2_diff;
   wire [`TCDR_GAIN_AW-1:0] gain_off;
   wire [`TCDR_F1_AW-1:0] f1_off;
   wire [`TCDR_F2_AW-1:0] f2_off;
   wire [7:0] gain_rdata;
   wire [7:0] f1_rdata [0:1];
   wire [7:0] f2_rdata [0:1];
   wire [15:0] f1_word_a [0:1];
   wire [15:0] f1_word_b [0:1];
   wire [15:0] f2_word_a [0:1];
   wire [15:0] f2_word_b [0:1];
   wire [4:0] probe_sel;

   // Host strobes, all active low and sampled on the clock
   assign host_wr = ~up_sel_n_in & ~up_wr_n_in;
   assign host_rd = ~up_sel_n_in & ~up_rd_n_in;

   // Address decode
   assign hit_probe = (up_addr_in == `TCDR_ADDR_PROBE_CTL);
   assign hit_f1_ctl = (up_addr_in == `TCDR_ADDR_F1_CTL);
   assign hit_f2_ctl = (up_addr_in == `TCDR_ADDR_F2_CTL);
   assign hit_gain = in_win(up_addr_in, `TCDR_GAIN_FIRST, `TCDR_GAIN_LAST);
   assign hit_f1 = in_win(up_addr_in, `TCDR_F1_FIRST, `TCDR_F1_LAST);
   assign hit_f2 = in_win(up_addr_in, `TCDR_F2_FIRST, `TCDR_F2_LAST);
   assign bank_hit = hit_probe | hit_f1_ctl | hit_f2_ctl | hit_gain | hit_f1 | hit_f2;

   // Drive the data bus only for reads that land in this bank
   assign up_data_oe_out = host_rd & bank_hit;

   // Offsets into each memory window
   assign gain_diff = up_addr_in - `TCDR_GAIN_FIRST;
   assign f1_diff = up_addr_in - `TCDR_F1_FIRST;
   assign f2_diff = up_addr_in - `TCDR_F2_FIRST;
   assign gain_off = gain_diff[`TCDR_GAIN_AW-1:0];
   assign f1_off = f1_diff[`TCDR_F1_AW-1:0];
   assign f2_off = f2_diff[`TCDR_F2_AW-1:0];

   // Control registers, host written
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         probe_ctl_r <= `TCDR_PROBE_CTL_RST;
         f1_ctl_r <= `TCDR_FIR_CTL_RST;
         f2_ctl_r <= `TCDR_FIR_CTL_RST;
      end else if (ce_in && host_wr) begin
         if (hit_probe) begin
            probe_ctl_r <= up_data_in;
         end
         if (hit_f1_ctl) begin
            f1_ctl_r <= up_data_in[`TCDR_FIR_CTL_W-1:0];
         end
         if (hit_f2_ctl) begin
            f2_ctl_r <= up_data_in[`TCDR_FIR_CTL_W-1:0];
         end
      end
   end

   // Dither enables and probe enable straight from the control register
   assign dither_enable_chan_a_out = probe_ctl_r[`TCDR_DITHER_ENABLE_CHAN_A_BIT];
   assign dither_enable_chan_b_out = probe_ctl_r[`TCDR_DITHER_ENABLE_CHAN_B_BIT];
   assign probe_en_out = probe_ctl_r[`TCDR_PROBE_EN_BIT];

   // Gain loop parameter RAM, one pair port per channel
   tcdr_mem #(
      .WORDS(`TCDR_GAIN_PAIRS),
      .BYTE_AW(`TCDR_GAIN_AW)
   ) u_gain_mem (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .host_addr_in(gain_off),
      .host_wr_in(host_wr & hit_gain),
      .host_wdata_in(up_data_in),
      .host_rdata_out(gain_rdata),
      .p0_idx_in(gain_pair_idx_a_in),
      .p0_word_out(gain_pair_a_out),
      .p1_idx_in(gain_pair_idx_b_in),
      .p1_word_out(gain_pair_b_out)
   );

   // Coefficient memories A (index 0) and B (index 1) for both stages
   genvar m;
   generate
      for (m = 0; m < 2; m = m + 1) begin : g_coef
         tcdr_mem #(
            .WORDS(`TCDR_F1_WORDS),
            .BYTE_AW(`TCDR_F1_AW)
         ) u_f1_mem (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .ce_in(ce_in),
            .host_addr_in(f1_off),
            .host_wr_in(host_wr & hit_f1 & (f1_ctl_r[`TCDR_PAGE_BIT] == m)),
            .host_wdata_in(up_data_in),
            .host_rdata_out(f1_rdata[m]),
            .p0_idx_in(f1_coef_idx_a_in),
            .p0_word_out(f1_word_a[m]),
            .p1_idx_in(f1_coef_idx_b_in),
            .p1_word_out(f1_word_b[m])
         );
         tcdr_mem #(
            .WORDS(`TCDR_F2_WORDS),
            .BYTE_AW(`TCDR_F2_AW)
         ) u_f2_mem (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .ce_in(ce_in),
            .host_addr_in(f2_off),
            .host_wr_in(host_wr & hit_f2 & (f2_ctl_r[`TCDR_PAGE_BIT] == m)),
            .host_wdata_in(up_data_in),
            .host_rdata_out(f2_rdata[m]),
            .p0_idx_in(f2_coef_idx_a_in),
            .p0_word_out(f2_word_a[m]),
            .p1_idx_in(f2_coef_idx_b_in),
            .p1_word_out(f2_word_b[m])
         );
      end
   endgenerate

   // Per-channel memory choice, registered onto the coefficient outputs
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         f1_coef_a_out <= 16'h0000;
         f1_coef_b_out <= 16'h0000;
         f2_coef_a_out <= 16'h0000;
         f2_coef_b_out <= 16'h0000;
      end else if (ce_in) begin
         f1_coef_a_out <= f1_word_a[f1_ctl_r[`TCDR_SEL_CHA_BIT]];
         f1_coef_b_out <= f1_word_b[f1_ctl_r[`TCDR_SEL_CHB_BIT]];
         f2_coef_a_out <= f2_word_a[f2_ctl_r[`TCDR_SEL_CHA_BIT]];
         f2_coef_b_out <= f2_word_b[f2_ctl_r[`TCDR_SEL_CHB_BIT]];
      end
   end

   // Read source decode; the page bit chooses which memory answers
   always @* begin
      rd_src_nxt = SRC_NONE;
      reg_rdata_nxt = `TCDR_BYTE_RST;
      if (hit_probe) begin
         rd_src_nxt = SRC_REG;
         reg_rdata_nxt = probe_ctl_r;
      end else if (hit_f1_ctl) begin
         rd_src_nxt = SRC_REG;
         reg_rdata_nxt = {5'h00, f1_ctl_r};
      end else if (hit_f2_ctl) begin
         rd_src_nxt = SRC_REG;
         reg_rdata_nxt = {5'h00, f2_ctl_r};
      end else if (hit_gain) begin
         rd_src_nxt = SRC_GAIN;
      end else if (hit_f1) begin
         rd_src_nxt = f1_ctl_r[`TCDR_PAGE_BIT] ? SRC_F1B : SRC_F1A;
      end else if (hit_f2) begin
         rd_src_nxt = f2_ctl_r[`TCDR_PAGE_BIT] ? SRC_F2B : SRC_F2A;
      end
   end

   // First read stage, alongside the memory read
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_src_r <= SRC_NONE;
         reg_rdata_r <= `TCDR_BYTE_RST;
      end else if (ce_in && host_rd) begin
         rd_src_r <= rd_src_nxt;
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   // Second read stage drives the host data bus from a flop
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         up_data_out <= `TCDR_BYTE_RST;
      end else if (ce_in) begin
         case (rd_src_r)
            SRC_REG: begin
               up_data_out <= reg_rdata_r;
            end
            SRC_GAIN: begin
               up_data_out <= gain_rdata;
            end
            SRC_F1A: begin
               up_data_out <= f1_rdata[0];
            end
            SRC_F1B: begin
               up_data_out <= f1_rdata[1];
            end
            SRC_F2A: begin
               up_data_out <= f2_rdata[0];
            end
            SRC_F2B: begin
               up_data_out <= f2_rdata[1];
            end
            default: begin
               up_data_out <= `TCDR_BYTE_RST;
            end
         endcase
      end
   end

   // Probe node multiplexer
   assign probe_sel = probe_ctl_r[`TCDR_PROBE_SEL_MSB:`TCDR_PROBE_SEL_LSB];

   always @* begin
      probe_nxt = 20'h00000;
      if (probe_sel[`TCDR_PROBE_AGC_BIT]) begin
         probe_nxt = {agc_cic_a_in, agc_cic_b_in, 2'h0};
      end else begin
         case (probe_sel)
            `TCDR_PRB_F1O_BI: begin
               probe_nxt = f1_out_bi_in;
            end
            `TCDR_PRB_F1O_BQ: begin
               probe_nxt = f1_out_bq_in;
            end
            `TCDR_PRB_F1O_AI: begin
               probe_nxt = f1_out_ai_in;
            end
            `TCDR_PRB_F1O_AQ: begin
               probe_nxt = f1_out_aq_in;
            end
            `TCDR_PRB_F1I_BI: begin
               probe_nxt = f1_in_bi_in;
            end
            `TCDR_PRB_F1I_BQ: begin
               probe_nxt = f1_in_bq_in;
            end
            `TCDR_PRB_F1I_AI: begin
               probe_nxt = f1_in_ai_in;
            end
            `TCDR_PRB_F1I_AQ: begin
               probe_nxt = f1_in_aq_in;
            end
            `TCDR_PRB_NCO_ACOS: begin
               probe_nxt = {nco_a_cos_in, 3'h0};
            end
            `TCDR_PRB_NCO_ASIN: begin
               probe_nxt = {nco_a_sin_in, 3'h0};
            end
            `TCDR_PRB_NCO_BCOS: begin
               probe_nxt = {nco_b_cos_in, 3'h0};
            end
            `TCDR_PRB_NCO_BSIN: begin
               probe_nxt = {nco_b_sin_in, 3'h0};
            end
            `TCDR_PRB_MIX_AI: begin
               probe_nxt = {mix_ai_in, 5'h00};
            end
            `TCDR_PRB_MIX_AQ: begin
               probe_nxt = {mix_aq_in, 5'h00};
            end
            `TCDR_PRB_MIX_BI: begin
               probe_nxt = {mix_bi_in, 5'h00};
            end
            `TCDR_PRB_MIX_BQ: begin
               probe_nxt = {mix_bq_in, 5'h00};
            end
            default: begin
               probe_nxt = 20'h00000;
            end
         endcase
      end
   end

   // Probe output held at zero unless probe access is enabled
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         probe_out <= 20'h00000;
      end else if (ce_in) begin
         probe_out <= probe_ctl_r[`TCDR_PROBE_EN_BIT] ? probe_nxt : 20'h00000;
      end
   end
endmodule // tcdr_top

// [hw/tcdr_regs.vh]
// Constants for the tuner coefficient and debug register bank.
// Assumes byte addresses from the 8-bit host port and a single device clock.
`ifndef TCDR_REGS_VH
`define TCDR_REGS_VH

// Single byte control registers
`define TCDR_ADDR_PROBE_CTL 8'h1f
`define TCDR_ADDR_F1_CTL 8'hf6
`define TCDR_ADDR_F2_CTL 8'hf7

// Memory windows, first and last byte address
`define TCDR_GAIN_FIRST 8'h80
`define TCDR_GAIN_LAST 8'h9f
`define TCDR_F1_FIRST 8'ha0
`define TCDR_F1_LAST 8'hb5
`define TCDR_F2_FIRST 8'hb6
`define TCDR_F2_LAST 8'hf5

// Field positions in the probe control register
`define TCDR_PROBE_EN_BIT 0
`define TCDR_PROBE_SEL_LSB 1
`define TCDR_PROBE_SEL_MSB 5
`define TCDR_PROBE_AGC_BIT 4
`define TCDR_DITHER_ENABLE_CHAN_A_BIT 6
`define TCDR_DITHER_ENABLE_CHAN_B_BIT 7

// Field positions in the two FIR control registers
`define TCDR_SEL_CHA_BIT 0
`define TCDR_SEL_CHB_BIT 1
`define TCDR_PAGE_BIT 2
`define TCDR_FIR_CTL_W 3

// Reset values
`define TCDR_PROBE_CTL_RST 8'hc0
`define TCDR_FIR_CTL_RST 3'h0
`define TCDR_BYTE_RST 8'h00

// Memory sizes in 16-bit words and byte address widths
`define TCDR_GAIN_PAIRS 16
`define TCDR_GAIN_AW 5
`define TCDR_F1_WORDS 11
`define TCDR_F1_AW 5
`define TCDR_F2_WORDS 32
`define TCDR_F2_AW 6

// Probe node selector codes
`define TCDR_PRB_F1O_BI 5'h00
`define TCDR_PRB_F1O_BQ 5'h01
`define TCDR_PRB_F1O_AI 5'h02
`define TCDR_PRB_F1O_AQ 5'h03
`define TCDR_PRB_F1I_BI 5'h04
`define TCDR_PRB_F1I_BQ 5'h05
`define TCDR_PRB_F1I_AI 5'h06
`define TCDR_PRB_NCO_ACOS 5'h07
`define TCDR_PRB_F1I_AQ 5'h08
`define TCDR_PRB_NCO_ASIN 5'h09
`define TCDR_PRB_NCO_BCOS 5'h0a
`define TCDR_PRB_NCO_BSIN 5'h0b
`define TCDR_PRB_MIX_AI 5'h0c
`define TCDR_PRB_MIX_AQ 5'h0d
`define TCDR_PRB_MIX_BI 5'h0e
`define TCDR_PRB_MIX_BQ 5'h0f

`endif

// [hw/tcdr_mem.v]
// Byte-wide host memory with two 16-bit word read ports for the datapath.
// Assumes the caller has already decoded the window and offset the address.
module tcdr_mem #(
   parameter WORDS = 11,
   parameter BYTE_AW = 5
) (
   input wire ref_clk_in,
   input wire rst_in,
   input wire ce_in,
   input wire [BYTE_AW-1:0] host_addr_in,
   input wire host_wr_in,
   input wire [7:0] host_wdata_in,
   output reg [7:0] host_rdata_out,
   input wire [BYTE_AW-2:0] p0_idx_in,
   output reg [15:0] p0_word_out,
   input wire [BYTE_AW-2:0] p1_idx_in,
   output reg [15:0] p1_word_out
);
`include "tcdr_regs.vh"

   localparam BYTES = 2 * WORDS;

   reg [7:0] mem_r [0:BYTES-1];
   integer i;

   // Word fetch, low byte at the even address, zero past the end
   function [15:0] rd_word;
      input [BYTE_AW-2:0] idx;
      begin
         if (idx < WORDS) begin
            rd_word = {mem_r[{idx, 1'b1}], mem_r[{idx, 1'b0}]};
         end else begin
            rd_word = 16'h0000;
         end
      end
   endfunction

   // Storage, cleared by reset
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (i = 0; i < BYTES; i = i + 1) begin
            mem_r[i] <= `TCDR_BYTE_RST;
         end
      end else if (ce_in && host_wr_in && (host_addr_in < BYTES)) begin
         mem_r[host_addr_in] <= host_wdata_in;
      end
   end

   // Registered read ports
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         host_rdata_out <= `TCDR_BYTE_RST;
         p0_word_out <= 16'h0000;
         p1_word_out <= 16'h0000;
      end else if (ce_in) begin
         host_rdata_out <= (host_addr_in < BYTES) ? mem_r[host_addr_in] : `TCDR_BYTE_RST;
         p0_word_out <= rd_word(p0_idx_in);
         p1_word_out <= rd_word(p1_idx_in);
      end
   end
endmodule // tcdr_mem

// [verif/tcdr_top_monitor.sv]
// Checker for the register bank ports: probe, dither and readback timing.
// Assumes one clock, async active-high reset and that it is bound to tcdr_top.
module tcdr_top_monitor (
   input wire ref_clk_in,
   input wire rst_in,
   input wire ce_in,
   input wire up_sel_n_in,
   input wire up_wr_n_in,
   input wire up_rd_n_in,
   input wire [7:0] up_addr_in,
   input wire [7:0] up_data_in,
   input wire [7:0] up_data_out,
   input wire up_data_oe_out,
   input wire [19:0] f1_out_ai_in,
   input wire [16:0] nco_a_cos_in,
   input wire [14:0] mix_ai_in,
   input wire [8:0] agc_cic_a_in,
   input wire [8:0] agc_cic_b_in,
   input wire [19:0] probe_out,
   input wire probe_en_out,
   input wire dither_enable_chan_a_out,
   input wire dither_enable_chan_b_out
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [7:0] probe_ctl_r;
   wire wr_ctl = ce_in && !up_sel_n_in && !up_wr_n_in && up_addr_in == 8'h1f;
   wire rd_ctl = ce_in && !up_sel_n_in && !up_rd_n_in && up_wr_n_in && up_addr_in == 8'h1f;
   wire on_r = ce_in && probe_ctl_r[0];
   wire [4:0] code = probe_ctl_r[5:1];
   wire in_bank = up_addr_in == 8'h1f || (up_addr_in >= 8'h80 && up_addr_in <= 8'hf7);
   // Shadow of the probe control byte, rebuilt from host writes
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         probe_ctl_r <= 8'hc0;
      end else if (wr_ctl) begin
         probe_ctl_r <= up_data_in;
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   property p_en; probe_en_out == probe_ctl_r[0]; endproperty
   a_en: assert property (p_en) else $error("probe enable differs");
   property p_off; $past(ce_in) && !$past(probe_ctl_r[0]) |-> probe_out == 20'h0; endproperty
   a_off: assert property (p_off) else $error("probe active while disabled");
   property p_dither_enable_chan_a; dither_enable_chan_a_out == probe_ctl_r[6]; endproperty
   a_dither_enable_chan_a: assert property (p_dither_enable_chan_a) else $error("dither a differs");
   property p_dither_enable_chan_b; dither_enable_chan_b_out == probe_ctl_r[7]; endproperty
   a_dither_enable_chan_b: assert property (p_dither_enable_chan_b) else $error("dither b differs");
   property p_f1; $past(on_r) && $past(code) == 5'h02 |-> probe_out == $past(f1_out_ai_in);
   endproperty
   a_f1: assert property (p_f1) else $error("filter tap wrong");
   property p_nco;
      $past(on_r) && $past(code) == 5'h07 |-> probe_out == {$past(nco_a_cos_in), 3'b000};
   endproperty
   a_nco: assert property (p_nco) else $error("oscillator tap wrong");
   property p_mix;
      $past(on_r) && $past(code) == 5'h0c |-> probe_out == {$past(mix_ai_in), 5'b00000};
   endproperty
   a_mix: assert property (p_mix) else $error("mixer tap wrong");
   property p_agc;
      $past(on_r) && $past(code[4]) |->
         probe_out == {$past(agc_cic_a_in), $past(agc_cic_b_in), 2'b00};
   endproperty
   a_agc: assert property (p_agc) else $error("detector tap wrong");
   property p_rd; rd_ctl [*3] |=> up_data_out == probe_ctl_r; endproperty
   a_rd: assert property (p_rd) else $error("control readback wrong");
   property p_oe; up_data_oe_out == (!up_sel_n_in && !up_rd_n_in && in_bank); endproperty
   a_oe: assert property (p_oe) else $error("bus drive enable wrong");
   property p_rst;
      disable iff (1'b0) rst_in |-> dither_enable_chan_a_out && dither_enable_chan_b_out
         && !probe_en_out && probe_out == 20'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset defaults wrong");
   // Main scenarios seen
   c_agc: cover property (wr_ctl && up_data_in[5] && up_data_in[0]);
   c_rd: cover property (rd_ctl [*3]);
   c_unmapped: cover property (!up_sel_n_in && !up_rd_n_in && !in_bank);
endmodule // tcdr_top_monitor

bind tcdr_top tcdr_top_monitor u_tcdr_top_monitor (.*);

// [verif/tcdr_host.sv]
// Host processor model for the 8-bit register port.
// Assumes the bench calls its tasks; bus lines change on the falling edge.
module tcdr_host (
   input wire ref_clk_in,
   input wire [7:0] rdata_in,
   input wire oe_in,
   output logic sel_n_out = 1'b1,
   output logic wr_n_out = 1'b1,
   output logic rd_n_out = 1'b1,
   output logic [7:0] addr_out = 8'h00,
   output logic [7:0] data_out = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // One write cycle; released data flips so a stale byte never looks valid
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      addr_out = a;
      data_out = d;
      sel_n_out = 1'b0;
      wr_n_out = 1'b0;
      @(negedge ref_clk_in);
      sel_n_out = 1'b1;
      wr_n_out = 1'b1;
      data_out = ~d;
      addr_out = ~a;
   endtask
   // Read held over three edges, sampled before the strobes drop
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic oe);
      @(negedge ref_clk_in);
      addr_out = a;
      sel_n_out = 1'b0;
      rd_n_out = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      d = rdata_in;
      oe = oe_in;
      sel_n_out = 1'b1;
      rd_n_out = 1'b1;
      addr_out = ~a;
   endtask
endmodule // tcdr_host

// [verif/tb_tcdr_top.sv]
// Self-checking bench for the tuner coefficient and debug register bank.
// Assumes tcdr_top with its checker bound; host bus comes from tcdr_host.
module tb_tcdr_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b0;
   logic ce_in = 1'b1;
   logic [19:0] f1_out_bi_in = 20'h0f001, f1_out_bq_in = 20'h1e002, f1_out_ai_in = 20'h2d003;
   logic [19:0] f1_out_aq_in = 20'h3c004, f1_in_bi_in = 20'h4b005, f1_in_bq_in = 20'h5a006;
   logic [19:0] f1_in_ai_in = 20'h69007, f1_in_aq_in = 20'h78008;
   logic [16:0] nco_a_cos_in = 17'h1a5a5, nco_a_sin_in = 17'h0c3c3;
   logic [16:0] nco_b_cos_in = 17'h15555, nco_b_sin_in = 17'h0aaaa;
   logic [14:0] mix_ai_in = 15'h1234, mix_aq_in = 15'h2345, mix_bi_in = 15'h3456;
   logic [14:0] mix_bq_in = 15'h4567;
   logic [8:0] agc_cic_a_in = 9'h1a5, agc_cic_b_in = 9'h0c3;
   logic [3:0] gain_pair_idx_a_in = 4'h0, gain_pair_idx_b_in = 4'h0;
   logic [3:0] f1_coef_idx_a_in = 4'h0, f1_coef_idx_b_in = 4'h0;
   logic [4:0] f2_coef_idx_a_in = 5'h0, f2_coef_idx_b_in = 5'h0;
   wire up_sel_n_in, up_wr_n_in, up_rd_n_in, up_data_oe_out, probe_en_out;
   wire dither_enable_chan_a_out, dither_enable_chan_b_out;
   wire [7:0] up_addr_in, up_data_in, up_data_out;
   wire [19:0] probe_out;
   wire [15:0] gain_pair_a_out, gain_pair_b_out, f1_coef_a_out, f1_coef_b_out;
   wire [15:0] f2_coef_a_out, f2_coef_b_out;
   int n_errors = 0;
   int samples_checked = 0;
   logic [4:0] row_code [0:17] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 31};

   tcdr_top u_tcdr_top (.*);
   tcdr_host u_tcdr_host (.ref_clk_in(ref_clk_in), .rdata_in(up_data_out),
      .oe_in(up_data_oe_out), .sel_n_out(up_sel_n_in), .wr_n_out(up_wr_n_in),
      .rd_n_out(up_rd_n_in), .addr_out(up_addr_in), .data_out(up_data_in));

   // 25 MHz clock
   always #20 ref_clk_in = ~ref_clk_in;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [19:0] e, input logic [19:0] got);
      samples_checked++;
      if (got !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_tcdr_host.wr_byte(a, d);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic oe;
      u_tcdr_host.rd_byte(a, d, oe);
      chk(what, {12'h0, e}, {12'h0, d});
   endtask

   task automatic settle(input int n, input string name);
      repeat (n) @(negedge ref_clk_in);
      if (name != "") $display("test %s done", name);
   endtask

   // Probe value that each selector code should route
   function automatic logic [19:0] exp_probe(input logic [4:0] c);
      if (c[4]) return {agc_cic_a_in, agc_cic_b_in, 2'b00};
      case (c)
         0: return f1_out_bi_in;
         1: return f1_out_bq_in;
         2: return f1_out_ai_in;
         3: return f1_out_aq_in;
         4: return f1_in_bi_in;
         5: return f1_in_bq_in;
         6: return f1_in_ai_in;
         7: return {nco_a_cos_in, 3'b000};
         8: return f1_in_aq_in;
         9: return {nco_a_sin_in, 3'b000};
         10: return {nco_b_cos_in, 3'b000};
         11: return {nco_b_sin_in, 3'b000};
         12: return {mix_ai_in, 5'h00};
         13: return {mix_aq_in, 5'h00};
         14: return {mix_bi_in, 5'h00};
         default: return {mix_bq_in, 5'h00};
      endcase
   endfunction

   // Watchdog at 5000 cycles, well beyond the fewer than 200 cycles the test takes
   initial begin
      #200000;
      n_errors++;
      $display("watchdog expired");
      stop_test();
   end

   initial begin
      logic [7:0] d;
      logic oe;
      logic [4:0] c;
      // Raise reset as an edge so the asynchronous branches fire before the first clock
      #1 rst_in = 1'b1;
      settle(16, "");
      rst_in = 1'b0;
      // Row loop: selector codes 0 to 16 and 31, dither bits varied alongside
      for (int i = 0; i < 18; i++) begin
         c = row_code[i];
         wr(8'h1f, {c[1:0], c, 1'b1});
         settle(2, "");
         chk("probe", exp_probe(c), probe_out);
         chk("dither_a", {19'h0, c[0]}, {19'h0, dither_enable_chan_a_out});
         chk("dither_b", {19'h0, c[1]}, {19'h0, dither_enable_chan_b_out});
      end
      settle(0, "probe_rows");
      wr(8'h1f, 8'h04);
      settle(2, "");
      chk("probe_off", 20'h0, probe_out);
      chk("probe_en", 20'h0, {19'h0, probe_en_out});
      settle(0, "probe_off");
      // Clock enable low: a host write must not land
      ce_in = 1'b0;
      wr(8'h1f, 8'hc1);
      settle(2, "");
      chk("dither_a_frozen", 20'h0, {19'h0, dither_enable_chan_a_out});
      chk("probe_en_frozen", 20'h0, {19'h0, probe_en_out});
      ce_in = 1'b1;
      settle(0, "clock_enable");
      // Gain RAM: both ends of the window and the datapath pairs
      wr(8'h80, 8'h81);
      wr(8'h81, 8'h12);
      wr(8'h9f, 8'h7f);
      gain_pair_idx_b_in = 4'hf;
      settle(2, "");
      chk("gain_a", 20'h01281, {4'h0, gain_pair_a_out});
      chk("gain_b", 20'h07f00, {4'h0, gain_pair_b_out});
      rd_chk("gain_last", 8'h9f, 8'h7f);
      settle(0, "gain_ram");
      // First stage: fill memory A, then page to memory B
      wr(8'ha0, 8'h34);
      wr(8'ha1, 8'h12);
      wr(8'hb4, 8'hcd);
      wr(8'hb5, 8'hab);
      wr(8'hf6, 8'h04);
      wr(8'ha0, 8'h78);
      wr(8'ha1, 8'h56);
      rd_chk("f1_page_b", 8'ha0, 8'h78);
      wr(8'hf6, 8'h02);
      rd_chk("f1_page_a", 8'ha0, 8'h34);
      chk("f1_a_mem_a", 20'h01234, {4'h0, f1_coef_a_out});
      chk("f1_b_mem_b", 20'h05678, {4'h0, f1_coef_b_out});
      wr(8'hf6, 8'h01);
      f1_coef_idx_b_in = 4'ha;
      settle(3, "");
      chk("f1_a_mem_b", 20'h05678, {4'h0, f1_coef_a_out});
      chk("f1_b_last", 20'h0abcd, {4'h0, f1_coef_b_out});
      settle(0, "first_fir");
      // Second stage: last coefficient of A, first of B
      wr(8'hb6, 8'h11);
      wr(8'hf4, 8'h33);
      wr(8'hf5, 8'h44);
      wr(8'hf7, 8'h04);
      wr(8'hb6, 8'h55);
      wr(8'hb7, 8'h66);
      wr(8'hf7, 8'h01);
      f2_coef_idx_b_in = 5'h1f;
      rd_chk("f2_page_a", 8'hf5, 8'h44);
      chk("f2_a_mem_b", 20'h06655, {4'h0, f2_coef_a_out});
      chk("f2_b_mem_a", 20'h04433, {4'h0, f2_coef_b_out});
      settle(0, "second_fir");
      // Unmapped address is not driven
      u_tcdr_host.rd_byte(8'h20, d, oe);
      chk("unmapped_oe", 20'h0, {19'h0, oe});
      chk("unmapped_data", 20'h0, {12'h0, d});
      settle(0, "unmapped");
      // Second reset in mid-run restores defaults
      rst_in = 1'b1;
      settle(16, "");
      rst_in = 1'b0;
      chk("dither_a_rst", 20'h1, {19'h0, dither_enable_chan_a_out});
      chk("dither_b_rst", 20'h1, {19'h0, dither_enable_chan_b_out});
      rd_chk("probe_ctl_rst", 8'h1f, 8'hc0);
      rd_chk("f1_ctl_rst", 8'hf6, 8'h00);
      rd_chk("gain_rst", 8'h80, 8'h00);
      settle(0, "reset");
      stop_test();
   end
endmodule // tb_tcdr_top
